// ===== shared/rac_consts.svh
// Constants for the alarm-compare and calibration block
`ifndef RAC_CONSTS_SVH
`define RAC_CONSTS_SVH

// ==================================================
// Register addresses (word index on the plain port)
`define RAC_ADDR_CAL        2'h0
`define RAC_ADDR_ALCFG      2'h1
`define RAC_ADDR_WIN        2'h2
`define RAC_ADDR_WIN_LO     2'h3

// ==================================================
// Writable-bit masks of the alarm value registers
`define RAC_MASK_MD         16'h1F3F
`define RAC_MASK_WH         16'h073F
`define RAC_MASK_MS         16'h7F7F

// ==================================================
// Window pointer codes
`define RAC_PTR_MS          2'h0
`define RAC_PTR_WH          2'h1
`define RAC_PTR_MD          2'h2

// ==================================================
// Alarm configuration field positions
`define RAC_CFG_EN          15
`define RAC_CFG_CHIME       14
`define RAC_CFG_MASK_HI     13
`define RAC_CFG_MASK_LO     10
`define RAC_CFG_PTR_HI      9
`define RAC_CFG_PTR_LO      8
`define RAC_CFG_RPT_HI      7
`define RAC_CFG_RPT_LO      0

// ==================================================
// Digit fields inside the value words
`define RAC_SEC_ONES        3:0
`define RAC_SEC_TENS        6:4
`define RAC_MIN_ONES        11:8
`define RAC_MIN_TENS        14:12
`define RAC_HOUR            5:0
`define RAC_WEEKDAY         10:8
`define RAC_DAY             5:0
`define RAC_MONTH           12:8
`define RAC_LOW_BYTE        7:0
`define RAC_HIGH_BYTE       15:8

// ==================================================
// Interval codes
`define RAC_IV_HALF         4'h0
`define RAC_IV_SEC          4'h1
`define RAC_IV_10SEC        4'h2
`define RAC_IV_MIN          4'h3
`define RAC_IV_10MIN        4'h4
`define RAC_IV_HOUR         4'h5
`define RAC_IV_DAY          4'h6
`define RAC_IV_WEEK         4'h7
`define RAC_IV_MONTH        4'h8
`define RAC_IV_YEAR         4'h9

// ==================================================
// Reset and fill values
`define RAC_ZERO16          16'h0000
`define RAC_ZERO8           8'h00
`define RAC_RPT_FULL        8'hFF
`define RAC_RPT_ONE         8'h01
`define RAC_PTR_ONE         2'h1
`define RAC_ZERO10          10'h000
`define RAC_CAL_PAD         2'h0

`endif

// ===== shared/rac_pkg.sv
// Types shared by the alarm-compare and calibration block
package rac_pkg;

  // ==================================================
  // Register port request
  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } rac_bus_t;

  // ==================================================
  // Running clock value from the time-keeping counters
  typedef struct packed {
    logic [15:0] month_day;
    logic [15:0] weekday_hour;
    logic [15:0] minute_second;
  } rac_time_t;

  // ==================================================
  // Complete state of the block
  typedef struct packed {
    logic [15:0] alarm_month_day;
    logic [15:0] alarm_weekday_hour;
    logic [15:0] alarm_minute_second;
    logic [7:0]  cal_value;
    logic        alarm_enable;
    logic        chime;
    logic [3:0]  alarm_interval_select;
    logic [1:0]  alarm_window_pointer;
    logic [7:0]  alarm_repeat_count;
    logic [15:0] rdata;
    logic        alarm_irq;
    logic        alarm_pulse;
    logic [9:0]  cal_adjust;
    logic        cal_adjust_valid;
  } rac_state_t;

endpackage

// ===== design/rac_alarm_cal.sv
// Alarm compare, repeat counter and calibration trim of the calendar clock unit
`timescale 1ns/1ps
`include "rac_consts.svh"

module rac_alarm_cal
  import rac_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire rac_bus_t    bus_req,
  output logic      [15:0] bus_rdata,
  input  wire rac_time_t   clock_now,
  input  wire logic        half_sec_tick,
  input  wire logic        second_half,
  input  wire logic        minute_tick,
  input  wire logic        clock_write_unlock,
  output logic             alarm_irq,
  output logic             alarm_pulse,
  output logic       [9:0] cal_adjust,
  output logic             cal_adjust_valid
);

  // ==================================================
  // Helper functions

  // Alarm value register selected by the window pointer
  function automatic logic [15:0] win_sel(input rac_state_t s);
    logic [15:0] v;
    v = `RAC_ZERO16;
    case (s.alarm_window_pointer)
      `RAC_PTR_MS: v = s.alarm_minute_second;
      `RAC_PTR_WH: v = s.alarm_weekday_hour;
      `RAC_PTR_MD: v = s.alarm_month_day;
      default:     v = `RAC_ZERO16;
    endcase
    return v;
  endfunction

  // Masked digit comparison for one interval code
  function automatic logic alarm_match(input logic [3:0] iv,
                                       input rac_state_t s,
                                       input rac_time_t  t);
    logic s1;
    logic s10;
    logic m1;
    logic m10;
    logic hr;
    logic wd;
    logic dy;
    logic mo;
    logic hit;
    s1  = s.alarm_minute_second[`RAC_SEC_ONES] == t.minute_second[`RAC_SEC_ONES];
    s10 = s.alarm_minute_second[`RAC_SEC_TENS] == t.minute_second[`RAC_SEC_TENS];
    m1  = s.alarm_minute_second[`RAC_MIN_ONES] == t.minute_second[`RAC_MIN_ONES];
    m10 = s.alarm_minute_second[`RAC_MIN_TENS] == t.minute_second[`RAC_MIN_TENS];
    hr  = s.alarm_weekday_hour[`RAC_HOUR] == t.weekday_hour[`RAC_HOUR];
    wd  = s.alarm_weekday_hour[`RAC_WEEKDAY] == t.weekday_hour[`RAC_WEEKDAY];
    dy  = s.alarm_month_day[`RAC_DAY] == t.month_day[`RAC_DAY];
    mo  = s.alarm_month_day[`RAC_MONTH] == t.month_day[`RAC_MONTH];
    hit = 1'b0;
    case (iv)
      `RAC_IV_HALF:  hit = 1'b1;
      `RAC_IV_SEC:   hit = 1'b1;
      `RAC_IV_10SEC: hit = s1;
      `RAC_IV_MIN:   hit = s1 & s10;
      `RAC_IV_10MIN: hit = s1 & s10 & m1;
      `RAC_IV_HOUR:  hit = s1 & s10 & m1 & m10;
      `RAC_IV_DAY:   hit = s1 & s10 & m1 & m10 & hr;
      `RAC_IV_WEEK:  hit = s1 & s10 & m1 & m10 & hr & wd;
      `RAC_IV_MONTH: hit = s1 & s10 & m1 & m10 & hr & dy;
      // Feb 29 match exists only in leap years
      `RAC_IV_YEAR:  hit = s1 & s10 & m1 & m10 & hr & dy & mo;
      // Reserved codes never fire
      default:       hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Store a value into an alarm register, keeping only implemented bits
  function automatic logic [15:0] put_val(input logic [15:0] old,
                                          input logic [15:0] val,
                                          input logic [15:0] msk,
                                          input logic        lo_only);
    logic [15:0] m;
    m = msk;
    if (lo_only) begin
      m[`RAC_HIGH_BYTE] = `RAC_ZERO8;
    end
    return (old & ~m) | (val & m);
  endfunction

  // ==================================================
  // State registers
  rac_state_t s_r;
  rac_state_t s_nxt;

  // Reset image: alarm off, values cleared
  localparam rac_state_t RESET_STATE = '{
    alarm_month_day:       `RAC_ZERO16,
    alarm_weekday_hour:    `RAC_ZERO16,
    alarm_minute_second:   `RAC_ZERO16,
    cal_value:             `RAC_ZERO8,
    alarm_enable:          1'b0,
    chime:                 1'b0,
    alarm_interval_select: `RAC_IV_HALF,
    alarm_window_pointer:  `RAC_PTR_MS,
    alarm_repeat_count:    `RAC_ZERO8,
    rdata:                 `RAC_ZERO16,
    alarm_irq:             1'b0,
    alarm_pulse:           1'b0,
    cal_adjust:            `RAC_ZERO10,
    cal_adjust_valid:      1'b0
  };

  // ==================================================
  // Combinational helpers
  logic        cal_write;
  logic        cfg_write;
  logic        win_access;
  logic        win_write;
  logic        lo_only;
  logic        cfg_en_w;
  logic        cfg_chime_w;
  logic [3:0]  cfg_iv_w;
  logic [1:0]  cfg_ptr_w;
  logic [7:0]  cfg_rpt_w;
  logic [15:0] win_word;
  logic [15:0] cfg_word;
  logic [15:0] read_word;
  logic        tick_live;
  logic        whole_sec_look;
  logic        digit_hit;
  logic        fire;
  logic        rpt_zero;
  logic        last_alarm;
  logic        rpt_wrap;

  // Bus decode; the master never raises both strobes together
  always_comb begin
    cal_write  = bus_req.wr & (bus_req.addr == `RAC_ADDR_CAL);
    cfg_write  = bus_req.wr & (bus_req.addr == `RAC_ADDR_ALCFG);
    win_access = (bus_req.wr | bus_req.rd) & (bus_req.addr == `RAC_ADDR_WIN);
    win_write  = bus_req.wr & ((bus_req.addr == `RAC_ADDR_WIN) |
                               (bus_req.addr == `RAC_ADDR_WIN_LO));
    // Low-byte alias: high byte and pointer left alone
    lo_only    = bus_req.addr == `RAC_ADDR_WIN_LO;
  end

  // Configuration fields as software writes them
  always_comb begin
    cfg_en_w    = bus_req.wdata[`RAC_CFG_EN];
    cfg_chime_w = bus_req.wdata[`RAC_CFG_CHIME];
    cfg_iv_w    = bus_req.wdata[`RAC_CFG_MASK_HI:`RAC_CFG_MASK_LO];
    cfg_ptr_w   = bus_req.wdata[`RAC_CFG_PTR_HI:`RAC_CFG_PTR_LO];
    cfg_rpt_w   = bus_req.wdata[`RAC_CFG_RPT_HI:`RAC_CFG_RPT_LO];
  end

  // Window word, taken before the pointer steps on the same access
  always_comb begin
    win_word = win_sel(s_r);
  end

  // Readable configuration word
  always_comb begin
    cfg_word                                        = `RAC_ZERO16;
    cfg_word[`RAC_CFG_EN]                           = s_r.alarm_enable;
    cfg_word[`RAC_CFG_CHIME]                        = s_r.chime;
    cfg_word[`RAC_CFG_MASK_HI:`RAC_CFG_MASK_LO]     = s_r.alarm_interval_select;
    cfg_word[`RAC_CFG_PTR_HI:`RAC_CFG_PTR_LO]       = s_r.alarm_window_pointer;
    cfg_word[`RAC_CFG_RPT_HI:`RAC_CFG_RPT_LO]       = s_r.alarm_repeat_count;
  end

  // Read multiplexer; the answer is registered for the next cycle
  always_comb begin
    read_word = `RAC_ZERO16;
    case (bus_req.addr)
      `RAC_ADDR_CAL:    read_word = {`RAC_ZERO8, s_r.cal_value};
      `RAC_ADDR_ALCFG:  read_word = cfg_word;
      `RAC_ADDR_WIN:    read_word = win_word;
      `RAC_ADDR_WIN_LO: read_word = {`RAC_ZERO8, win_word[`RAC_LOW_BYTE]};
      default:          read_word = `RAC_ZERO16;
    endcase
  end

  // Alarm decision, only on half-second ticks and while enabled
  always_comb begin
    tick_live      = half_sec_tick & s_r.alarm_enable;
    // Whole-second intervals look only in the first half of the second
    whole_sec_look = tick_live & ~second_half;
    digit_hit      = alarm_match(s_r.alarm_interval_select, s_r, clock_now);
    fire           = 1'b0;
    if (tick_live && s_r.alarm_interval_select == `RAC_IV_HALF) begin
      fire = 1'b1;
    end else if (whole_sec_look) begin
      fire = digit_hit;
    end
  end

  // Repeat outcome of an event, judged on the settled count
  always_comb begin
    rpt_zero   = s_r.alarm_repeat_count == `RAC_ZERO8;
    last_alarm = fire & rpt_zero & ~s_r.chime;
    rpt_wrap   = fire & rpt_zero & s_r.chime;
  end

  // ==================================================
  // Next-state logic
  always_comb begin
    s_nxt                  = s_r;
    s_nxt.alarm_irq        = 1'b0;
    s_nxt.cal_adjust_valid = 1'b0;
    s_nxt.rdata            = `RAC_ZERO16;

    // Register reads, data stands one cycle later
    if (bus_req.rd) begin
      s_nxt.rdata = read_word;
    end

    // Calibration and configuration writes; calibration high byte ignored
    if (cal_write) begin
      s_nxt.cal_value = bus_req.wdata[`RAC_LOW_BYTE];
    end
    if (cfg_write) begin
      s_nxt.alarm_enable          = cfg_en_w;
      s_nxt.chime                 = cfg_chime_w;
      s_nxt.alarm_interval_select = cfg_iv_w;
      s_nxt.alarm_window_pointer  = cfg_ptr_w;
      s_nxt.alarm_repeat_count    = cfg_rpt_w;
    end

    // Window writes land in the register the pointer selects; weekday/hour and month/day only while clock_write_unlock is high
    if (win_write) begin
      case (s_r.alarm_window_pointer)
        `RAC_PTR_MS: begin
          s_nxt.alarm_minute_second = put_val(s_r.alarm_minute_second, bus_req.wdata,
                                              `RAC_MASK_MS, lo_only);
        end
        `RAC_PTR_WH: begin
          if (clock_write_unlock) begin
            s_nxt.alarm_weekday_hour = put_val(s_r.alarm_weekday_hour, bus_req.wdata,
                                               `RAC_MASK_WH, lo_only);
          end
        end
        `RAC_PTR_MD: begin
          if (clock_write_unlock) begin
            s_nxt.alarm_month_day = put_val(s_r.alarm_month_day, bus_req.wdata,
                                            `RAC_MASK_MD, lo_only);
          end
        end
        default: begin
          s_nxt.alarm_month_day = s_r.alarm_month_day;
        end
      endcase
    end

    // pointer steps down, holds at zero
    if (win_access && s_r.alarm_window_pointer != `RAC_PTR_MS) begin
      s_nxt.alarm_window_pointer = s_r.alarm_window_pointer - `RAC_PTR_ONE;
    end

    // Alarm event; applied after software so an event is never lost
    if (fire) begin
      s_nxt.alarm_irq   = 1'b1;
      s_nxt.alarm_pulse = ~s_r.alarm_pulse;
      if (rpt_wrap) begin
        s_nxt.alarm_repeat_count = `RAC_RPT_FULL;
      end else if (last_alarm) begin
        s_nxt.alarm_enable = 1'b0;
      end else begin
        s_nxt.alarm_repeat_count = s_r.alarm_repeat_count - `RAC_RPT_ONE;
      end
    end

    // Once-a-minute trim, signed value times four
    if (minute_tick) begin
      s_nxt.cal_adjust       = {s_r.cal_value, `RAC_CAL_PAD};
      s_nxt.cal_adjust_valid = 1'b1;
    end
  end

  // ==================================================
  // State register, synchronous active-low reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==================================================
  // Outputs straight from the state flops
  assign bus_rdata        = s_r.rdata;
  assign alarm_irq        = s_r.alarm_irq;
  assign alarm_pulse      = s_r.alarm_pulse;
  assign cal_adjust       = s_r.cal_adjust;
  assign cal_adjust_valid = s_r.cal_adjust_valid;

endmodule

// ===== tb/rac_alarm_cal_props.sv
// Port-level checker for the alarm-compare and calibration block
`timescale 1ns/1ps
`include "rac_consts.svh"
module rac_alarm_cal_props
  import rac_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire rac_bus_t    bus_req,
  input wire logic [15:0] bus_rdata,
  input wire rac_time_t   clock_now,
  input wire logic        half_sec_tick,
  input wire logic        second_half,
  input wire logic        minute_tick,
  input wire logic        clock_write_unlock,
  input wire logic        alarm_irq,
  input wire logic        alarm_pulse,
  input wire logic [9:0]  cal_adjust,
  input wire logic        cal_adjust_valid
);
  // ====================
  // One domain, so one clock and reset
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // ====================
  // Alarm events
  chk_irq_on_tick: assert property (alarm_irq |-> $past(half_sec_tick))
    else $error("alarm event without a half-second tick");
  chk_irq_one_cycle: assert property (alarm_irq && !half_sec_tick |=> !alarm_irq)
    else $error("alarm request longer than one cycle");
  chk_pulse_toggle: assert property ((alarm_pulse != $past(alarm_pulse)) == alarm_irq)
    else $error("alarm pulse not toggling with events");

  // ====================
  // Calibration trim
  chk_cal_strobe: assert property (minute_tick |=> cal_adjust_valid)
    else $error("no trim strobe after minute tick");
  chk_cal_cause: assert property (cal_adjust_valid |-> $past(minute_tick))
    else $error("trim strobe without minute tick");
  chk_cal_hold: assert property (!cal_adjust_valid |-> $stable(cal_adjust))
    else $error("trim value moved between minutes");
  chk_cal_times4: assert property (cal_adjust[1:0] == 2'h0)
    else $error("trim value not a multiple of four");

  // ====================
  // Read data framing and empty bits
  chk_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == `RAC_ZERO16)
    else $error("read data outside the answer cycle");
  chk_rdata_resv: assert property ($past(bus_req.rd) && $past(bus_req.addr[1]) |-> !bus_rdata[15] && !bus_rdata[7])
    else $error("unimplemented alarm bit reads one");
  chk_low_only: assert property ($past(bus_req.rd) && $past(bus_req.addr) inside {`RAC_ADDR_CAL, `RAC_ADDR_WIN_LO}
                                 |-> bus_rdata[15:8] == `RAC_ZERO8)
    else $error("high byte of a low-byte register reads nonzero");
endmodule

bind rac_alarm_cal rac_alarm_cal_props rac_alarm_cal_props_i (
  .core_clk           (core_clk),
  .rst_b              (rst_b),
  .bus_req            (bus_req),
  .bus_rdata          (bus_rdata),
  .clock_now          (clock_now),
  .half_sec_tick      (half_sec_tick),
  .second_half        (second_half),
  .minute_tick        (minute_tick),
  .clock_write_unlock (clock_write_unlock),
  .alarm_irq          (alarm_irq),
  .alarm_pulse        (alarm_pulse),
  .cal_adjust         (cal_adjust),
  .cal_adjust_valid   (cal_adjust_valid)
);

// ===== tb/tb_rac_alarm_cal.sv
// Self-checking testbench for the alarm-compare and calibration block
`timescale 1ns/1ps
`include "rac_consts.svh"
module tb_rac_alarm_cal
  import rac_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  rac_bus_t    bus_req = '0;
  logic [15:0] bus_rdata;
  rac_time_t   clock_now = '0;
  logic        half_sec_tick = 1'b0;
  logic        second_half = 1'b0;
  logic        minute_tick = 1'b0;
  logic        clock_write_unlock = 1'b0;
  logic        alarm_irq;
  logic        alarm_pulse;
  logic [9:0]  cal_adjust;
  logic        cal_adjust_valid;
  logic [15:0] rd_q[$];
  logic        irq_q[$];
  logic [9:0]  cal_q[$];
  logic        rd_pend = 1'b0;
  logic        pulse_e = 1'b0;
  int          err_total = 0;
  int          total_checks = 0;
  // Digits flipped outside and inside what each interval code compares
  logic [47:0] outb [16] = '{48'h111101111111, 48'h111101111111, 48'h111101111110, 48'h111101111100,
                             48'h111101111000, 48'h111101110000, 48'h111101000000, 48'h111100000000,
                             48'h110001000000, 48'h000001000000, 48'h0, 48'h0, 48'h0, 48'h0, 48'h0, 48'h0};
  logic [47:0] inb [16] = '{48'h0, 48'h0, 48'h1, 48'h10, 48'h100, 48'h1000, 48'h100000, 48'h1000000,
                            48'h100000000, 48'h10000000000, 48'h0, 48'h0, 48'h0, 48'h0, 48'h0, 48'h0};

  // ====================
  // Clock and design
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  rac_alarm_cal rac_alarm_cal_i (
    .core_clk           (core_clk),
    .rst_b              (rst_b),
    .bus_req            (bus_req),
    .bus_rdata          (bus_rdata),
    .clock_now          (clock_now),
    .half_sec_tick      (half_sec_tick),
    .second_half        (second_half),
    .minute_tick        (minute_tick),
    .clock_write_unlock (clock_write_unlock),
    .alarm_irq          (alarm_irq),
    .alarm_pulse        (alarm_pulse),
    .cal_adjust         (cal_adjust),
    .cal_adjust_valid   (cal_adjust_valid)
  );

  // ====================
  // Comparison and verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input bit ok);
    total_checks++;
    if (!ok || got !== exp) begin
      err_total++;
      $display("unexpected result at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Queue state is taken before the pop, whatever the argument order
  task automatic cmp_rd(input logic [15:0] got);
    bit          ok;
    logic [15:0] e;
    ok = rd_q.size() > 0;
    e  = ok ? rd_q.pop_front() : 16'h0;
    check(got, e, ok);
  endtask
  task automatic cmp_irq(input logic got);
    bit   ok;
    logic e;
    ok = irq_q.size() > 0;
    e  = ok ? irq_q.pop_front() : 1'b0;
    check({15'h0, got}, {15'h0, e}, ok);
  endtask
  task automatic cmp_cal(input logic [9:0] got);
    bit         ok;
    logic [9:0] e;
    ok = cal_q.size() > 0;
    e  = ok ? cal_q.pop_front() : 10'h0;
    check({6'h0, got}, {6'h0, e}, ok);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watches outputs; read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_pend) cmp_rd(bus_rdata);
    if (alarm_irq === 1'b1) cmp_irq(alarm_pulse);
    if (cal_adjust_valid === 1'b1) cmp_cal(cal_adjust);
    rd_pend <= bus_req.rd;
  end

  // ====================
  // Bus and event drivers
  task automatic bus_op(input logic [1:0] a, input logic [15:0] d, input logic w);
    @(posedge core_clk);
    bus_req <= '{a, d, w, !w};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    bus_op(a, d, 1'b1);
  endtask
  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    bus_op(a, `RAC_ZERO16, 1'b0);
  endtask
  // Pointer starts at month/day and walks down per window access
  task automatic set_alm(input logic [47:0] v);
    wr(`RAC_ADDR_ALCFG, 16'h0200);
    wr(`RAC_ADDR_WIN, v[47:32]);
    wr(`RAC_ADDR_WIN, v[31:16]);
    wr(`RAC_ADDR_WIN, v[15:0]);
  endtask
  task automatic chk_alm(input logic [47:0] e);
    wr(`RAC_ADDR_ALCFG, 16'h0200);
    rd(`RAC_ADDR_WIN, e[47:32]);
    rd(`RAC_ADDR_WIN, e[31:16]);
    rd(`RAC_ADDR_WIN, e[15:0]);
  endtask
  task automatic tick(input logic sh, input logic fire);
    if (fire) begin
      pulse_e = ~pulse_e;
      irq_q.push_back(pulse_e);
    end
    @(posedge core_clk);
    half_sec_tick <= 1'b1;
    second_half <= sh;
    @(posedge core_clk);
    half_sec_tick <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic arm(input logic [3:0] c);
    wr(`RAC_ADDR_ALCFG, {2'h2, c, 10'h000});
  endtask

  // ====================
  // Main sequence
  initial begin
    logic [47:0] m;
    logic [7:0]  c8;
    void'($urandom(32'h4767));
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(`RAC_ADDR_CAL, `RAC_ZERO16);
    rd(`RAC_ADDR_ALCFG, `RAC_ZERO16);
    // Random fill shows which bits hold; pointer must stop at zero
    clock_write_unlock <= 1'b1;
    m = {16'($urandom), 32'($urandom)};
    set_alm(m);
    rd(`RAC_ADDR_ALCFG, `RAC_ZERO16);
    m = m & {`RAC_MASK_MD, `RAC_MASK_WH, `RAC_MASK_MS};
    chk_alm(m);
    rd(`RAC_ADDR_WIN, m[15:0]);
    rd(`RAC_ADDR_WIN_LO, {8'h00, m[7:0]});
    // Locked writes dropped except minute/second
    clock_write_unlock <= 1'b0;
    set_alm(48'h0);
    chk_alm({m[47:16], 16'h0000});
    clock_write_unlock <= 1'b1;
    set_alm(48'h1225_0315_4537);
    // Every interval code: ignored digits, one compared digit, second half
    for (int c = 0; c < 16; c++) begin
      clock_now <= 48'h1225_0315_4537 ^ outb[c];
      arm(c[3:0]);
      tick(1'b0, c < 10);
      clock_now <= 48'h1225_0315_4537 ^ inb[c];
      arm(c[3:0]);
      tick(1'b0, c < 2);
      clock_now <= 48'h1225_0315_4537;
      arm(c[3:0]);
      tick(1'b1, c == 0);
    end
    arm(4'h0);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b0);
    rd(`RAC_ADDR_ALCFG, `RAC_ZERO16);
    // Repeat counter down to the last alarm, then wrap with chime
    wr(`RAC_ADDR_ALCFG, 16'h8002);
    tick(1'b0, 1'b1);
    rd(`RAC_ADDR_ALCFG, 16'h8001);
    repeat (2) tick(1'b0, 1'b1);
    tick(1'b0, 1'b0);
    rd(`RAC_ADDR_ALCFG, `RAC_ZERO16);
    wr(`RAC_ADDR_ALCFG, 16'hC000);
    tick(1'b0, 1'b1);
    rd(`RAC_ADDR_ALCFG, 16'hC0FF);
    tick(1'b0, 1'b1);
    rd(`RAC_ADDR_ALCFG, 16'hC0FE);
    wr(`RAC_ADDR_ALCFG, `RAC_ZERO16);
    // Trim extremes and a random value; written while no second is running
    for (int i = 0; i < 5; i++) begin
      c8 = (i < 4) ? 8'(32'h7F80_FF01 >> (8 * i)) : 8'($urandom);
      wr(`RAC_ADDR_CAL, {8'($urandom), c8});
      rd(`RAC_ADDR_CAL, {8'h00, c8});
      cal_q.push_back(10'($signed(c8) * 4));
      @(posedge core_clk);
      minute_tick <= 1'b1;
      @(posedge core_clk);
      minute_tick <= 1'b0;
    end
    // Bounded drain; anything still owed is a miss
    for (int i = 0; i < 20 && rd_q.size() + irq_q.size() + cal_q.size() > 0; i++) @(posedge core_clk);
    if (rd_q.size() + irq_q.size() + cal_q.size() > 0) begin
      err_total++;
      $display("unexpected missing results at %0t: got %h expected %h", $time, 0, rd_q.size() + irq_q.size());
    end
    conclude();
  end
endmodule
